// ===== rtl/papc_params.svh
// Offsets, field positions, reset values and masks for the port A pad block
`ifndef PAPC_PARAMS_SVH
`define PAPC_PARAMS_SVH
`define PAPC_OFF_DIRECTION 12'hF00
`define PAPC_OFF_LATCH 12'hF04
`define PAPC_OFF_PINS 12'hF08
`define PAPC_OFF_ANALOG 12'hF0C
`define PAPC_OFF_MISC 12'hF10
`define PAPC_OFF_PAD_CONFIG_ONE 12'hF3C
`define PAPC_OFF_OPEN_DRAIN_THREE 12'hF40
`define PAPC_PORT_MASK 8'hEF
`define PAPC_ANALOG_MASK 8'h1F
`define PAPC_MISC_MASK 8'h0F
`define PAPC_ODC3_MASK 8'h83
`define PAPC_PADCFG_MASK 8'h07
`define PAPC_RST_DIRECTION 8'hEF
`define PAPC_RST_LATCH 8'h00
`define PAPC_RST_ANALOG 8'h00
`define PAPC_RST_MISC 8'h00
`define PAPC_RST_ODC3 8'h00
`define PAPC_RST_PADCFG 8'h00
`define PAPC_BIT_SPI1_OD 0
`define PAPC_BIT_SPI2_OD 1
`define PAPC_BIT_PULSE_DELAY 7
`define PAPC_BIT_TTL 0
`define PAPC_BIT_CAL_SEL_LO 1
`define PAPC_BIT_CAL_SEL_HI 2
`define PAPC_BIT_CAL_OE 0
`define PAPC_BIT_CAL_OSC 1
`define PAPC_BIT_TMR_OSC 2
`define PAPC_BIT_BANDGAP 3
`define PAPC_RESP_OKAY 2'h0
`define PAPC_RESP_SLVERR 2'h2
`endif

// ===== rtl/papc_pkg.sv
// Types for the port A pad block
package papc_pkg;
    typedef enum logic [1:0] {
        cal_alarm,
        cal_seconds,
        cal_source,
        cal_reserved
    } papc_cal_sel_type;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] schmitt;
    } papc_pad_type;
    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] latch;
        logic [7:0] analog;
        logic [7:0] misc;
        logic [7:0] odc3;
        logic [7:0] padcfg;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [4:0] cal_s1;
        logic [4:0] cal_s2;
        logic [4:0] cal_s3;
        logic [4:0] cal_lvl;
        logic [7:0] pins;
        papc_pad_type pad;
        logic cal_out;
        logic cal_oe;
        logic pulse_delay;
        logic [1:0] par_in;
        logic bandgap;
        logic ttl;
        logic [7:0] ana_en;
        logic aw_full;
        logic [11:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } papc_state_type;
endpackage : papc_pkg

// ===== rtl/papc_top.sv
// Port A pad control with AXI4-Lite register access
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "papc_params.svh"
module papc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Unused protection
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Unused protection
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [7:0] pad_in, // Pin levels
    output papc_pkg::papc_pad_type pad, // Pin drive, enable, buffer type
    input wire logic osc_pins_taken, // Oscillator owns pins six and seven
    input wire logic [1:0] remap_active, // Remapped peripheral on pins zero, one
    input wire logic [1:0] remap_out, // Remapped peripheral output data
    input wire logic [1:0] remap_is_spi1, // Remapped output is serial port one
    input wire logic [1:0] remap_is_spi2, // Remapped output is serial port two
    input wire logic [1:0] par_own, // Parallel port owns pins zero, one
    input wire logic [1:0] par_out, // Parallel port output data
    input wire logic [1:0] par_oe, // Parallel port output enable
    output logic [1:0] par_in, // Parallel port input from pins
    output logic parallel_port_ttl_select, // Parallel inputs use TTL
    output logic pulse_delay_input, // Pulse-delay input to timing unit
    output logic bandgap_out, // Band-gap reference on pin one
    output logic [7:0] analog_in_enable, // Converter input per pin
    input wire logic cal_alarm_pulse, // Calendar alarm pulse
    input wire logic cal_seconds_clock, // Calendar seconds clock
    input wire logic intrc_clk, // Internal RC clock level
    input wire logic sec_osc_clk, // Secondary oscillator level
    input wire logic ext_timer_clk, // External timer clock level
    output logic calendar_pin_out, // Calendar pin data
    output logic calendar_pin_oe // Calendar pin drive enable
);
    import papc_pkg::*;

    papc_state_type st_reg;
    papc_state_type st_next;

    function automatic logic [7:0] merge_wr(
        input logic [7:0] old,
        input logic [7:0] data,
        input logic [7:0] mask
    );
        merge_wr = (old & ~mask) | (data & mask);
    endfunction : merge_wr

    function automatic logic [7:0] accept_sync(
        input logic [7:0] held,
        input logic [7:0] s2,
        input logic [7:0] s3
    );
        accept_sync = (held & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
    endfunction : accept_sync

    logic [7:0] dig_mask;
    logic [7:0] pin_read;
    logic [7:0] rd_val;
    logic rd_hit;
    logic do_write;
    papc_cal_sel_type cal_sel;
    logic cal_src;
    logic od_on;
    logic spi1_od;
    logic spi2_od;
    logic [7:0] cal_acc;

    always_comb
    begin
        st_next = st_reg;
        dig_mask = {~osc_pins_taken, ~osc_pins_taken, st_reg.analog[4], 1'b0,
            st_reg.analog[3:0]};
        pin_read = st_reg.pins & dig_mask;
        rd_hit = 1'b1;
        rd_val = 8'h00;
        do_write = 1'b0;
        od_on = 1'b0;
        cal_src = 1'b0;
        spi1_od = st_reg.odc3[`PAPC_BIT_SPI1_OD];
        spi2_od = st_reg.odc3[`PAPC_BIT_SPI2_OD];
        cal_sel = papc_cal_sel_type'(st_reg.padcfg[`PAPC_BIT_CAL_SEL_HI:`PAPC_BIT_CAL_SEL_LO]);

        // Three-stage pin sampler
        st_next.sync1 = pad_in;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        st_next.pins = accept_sync(st_reg.pins, st_reg.sync2, st_reg.sync3);

        // Calendar and oscillator levels come from slow clocks
        st_next.cal_s1 = {cal_seconds_clock, cal_alarm_pulse, ext_timer_clk, sec_osc_clk,
            intrc_clk};
        st_next.cal_s2 = st_reg.cal_s1;
        st_next.cal_s3 = st_reg.cal_s2;
        cal_acc = accept_sync({3'b000, st_reg.cal_lvl}, {3'b000, st_reg.cal_s2},
            {3'b000, st_reg.cal_s3});
        st_next.cal_lvl = cal_acc[4:0];

        // Write channel capture in either order
        if (s_axi_awvalid && st_reg.awready)
        begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = 12'(s_axi_awaddr);
        end
        if (s_axi_wvalid && st_reg.wready)
        begin
            st_next.w_full = 1'b1;
            st_next.w_data = s_axi_wdata[7:0];
            st_next.w_strb = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready)
        begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid)
        begin
            do_write = 1'b1;
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `PAPC_RESP_OKAY;
        end
        if (do_write)
        begin
            case (st_reg.aw_addr)
                `PAPC_OFF_DIRECTION:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.direction = merge_wr(st_reg.direction, st_reg.w_data,
                            `PAPC_PORT_MASK);
                    end
                end
                `PAPC_OFF_LATCH, `PAPC_OFF_PINS:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.latch = merge_wr(st_reg.latch, st_reg.w_data,
                            `PAPC_PORT_MASK);
                    end
                end
                `PAPC_OFF_ANALOG:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.analog = merge_wr(st_reg.analog, st_reg.w_data,
                            `PAPC_ANALOG_MASK);
                    end
                end
                `PAPC_OFF_MISC:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.misc = merge_wr(st_reg.misc, st_reg.w_data,
                            `PAPC_MISC_MASK);
                    end
                end
                `PAPC_OFF_OPEN_DRAIN_THREE:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.odc3 = merge_wr(st_reg.odc3, st_reg.w_data,
                            `PAPC_ODC3_MASK);
                    end
                end
                `PAPC_OFF_PAD_CONFIG_ONE:
                begin
                    if (st_reg.w_strb)
                    begin
                        st_next.padcfg = merge_wr(st_reg.padcfg, st_reg.w_data,
                            `PAPC_PADCFG_MASK);
                    end
                end
                default:
                begin
                    st_next.bresp = `PAPC_RESP_SLVERR;
                end
            endcase
        end

        // Read decode
        case (s_axi_araddr)
            `PAPC_OFF_DIRECTION:
            begin
                rd_val = st_reg.direction;
            end
            `PAPC_OFF_LATCH:
            begin
                rd_val = st_reg.latch;
            end
            `PAPC_OFF_PINS:
            begin
                rd_val = pin_read;
            end
            `PAPC_OFF_ANALOG:
            begin
                rd_val = st_reg.analog;
            end
            `PAPC_OFF_MISC:
            begin
                rd_val = st_reg.misc;
            end
            `PAPC_OFF_OPEN_DRAIN_THREE:
            begin
                rd_val = st_reg.odc3 & `PAPC_ODC3_MASK;
            end
            `PAPC_OFF_PAD_CONFIG_ONE:
            begin
                rd_val = st_reg.padcfg & `PAPC_PADCFG_MASK;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
        if (st_reg.rvalid && s_axi_rready)
        begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata = {24'h000000, rd_val};
            st_next.rresp = rd_hit ? `PAPC_RESP_OKAY : `PAPC_RESP_SLVERR;
        end
        st_next.awready = !st_next.aw_full && !st_next.bvalid;
        st_next.wready = !st_next.w_full && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;

        // Pad drivers, latch and direction by default
        st_next.pad.out = st_reg.latch & `PAPC_PORT_MASK;
        st_next.pad.oe = ~st_reg.direction & `PAPC_PORT_MASK;
        st_next.pad.schmitt = 8'h00;
        for (int i = 0; i < 2; i++)
        begin
            od_on = (remap_is_spi1[i] && spi1_od) || (remap_is_spi2[i] && spi2_od);
            if (par_own[i])
            begin
                st_next.pad.out[i] = par_out[i];
                st_next.pad.oe[i] = par_oe[i];
                st_next.pad.schmitt[i] = !st_reg.padcfg[`PAPC_BIT_TTL];
            end
            else if (remap_active[i])
            begin
                st_next.pad.schmitt[i] = st_reg.direction[i];
                if (od_on)
                begin
                    st_next.pad.out[i] = 1'b0;
                    st_next.pad.oe[i] = !st_reg.direction[i] && !remap_out[i];
                end
                else
                begin
                    st_next.pad.out[i] = remap_out[i];
                end
            end
        end
        if (osc_pins_taken)
        begin
            st_next.pad.out[7:6] = 2'b00;
            st_next.pad.oe[7:6] = 2'b00;
        end

        // Peripheral side of the pins
        st_next.par_in = st_reg.pins[1:0];
        st_next.ttl = st_reg.padcfg[`PAPC_BIT_TTL];
        st_next.pulse_delay = st_reg.odc3[`PAPC_BIT_PULSE_DELAY] && st_reg.pins[1];
        st_next.bandgap = st_reg.misc[`PAPC_BIT_BANDGAP];
        st_next.ana_en = {2'b00, ~st_reg.analog[4], 1'b0, ~st_reg.analog[3:0]};

        // Calendar pin source
        if (!st_reg.misc[`PAPC_BIT_CAL_OSC])
        begin
            cal_src = st_reg.cal_lvl[0];
        end
        else if (st_reg.misc[`PAPC_BIT_TMR_OSC])
        begin
            cal_src = st_reg.cal_lvl[1];
        end
        else
        begin
            cal_src = st_reg.cal_lvl[2];
        end
        case (cal_sel)
            cal_alarm: st_next.cal_out = st_reg.cal_lvl[3];
            cal_seconds: st_next.cal_out = st_reg.cal_lvl[4];
            cal_source: st_next.cal_out = cal_src;
            cal_reserved: st_next.cal_out = 1'b0;
            default: st_next.cal_out = 1'b0;
        endcase
        st_next.cal_oe = st_reg.misc[`PAPC_BIT_CAL_OE];
        if (!st_reg.misc[`PAPC_BIT_CAL_OE])
        begin
            st_next.cal_out = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.direction <= `PAPC_RST_DIRECTION;
            st_reg.latch <= `PAPC_RST_LATCH;
            st_reg.analog <= `PAPC_RST_ANALOG;
            st_reg.misc <= `PAPC_RST_MISC;
            st_reg.odc3 <= `PAPC_RST_ODC3;
            st_reg.padcfg <= `PAPC_RST_PADCFG;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign pad = st_reg.pad;
    assign par_in = st_reg.par_in;
    assign parallel_port_ttl_select = st_reg.ttl;
    assign pulse_delay_input = st_reg.pulse_delay;
    assign bandgap_out = st_reg.bandgap;
    assign analog_in_enable = st_reg.ana_en;
    assign calendar_pin_out = st_reg.cal_out;
    assign calendar_pin_oe = st_reg.cal_oe;
endmodule : papc_top
`default_nettype wire

// ===== verif/papc_pin_model.sv
// Board-side model of the port A pins
`timescale 1ns/10ps
`default_nettype none
module papc_pin_model (
    input wire papc_pkg::papc_pad_type pad, // Pad drive from the block
    input wire logic [7:0] world, // Board level on released pins
    output logic [7:0] pad_in // Resolved pin levels
);
    import papc_pkg::*;
    // Driven pins follow the pad, released pins fall to the board level
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & world);
endmodule : papc_pin_model
`default_nettype wire

// ===== verif/papc_top_asserts.sv
// Port-level checks for the port A pad block
`timescale 1ns/10ps
`default_nettype none
`include "papc_params.svh"
module papc_top_asserts #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read valid
    input wire logic s_axi_arready, // Read ready
    input wire logic s_axi_rvalid, // Data valid
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic osc_pins_taken, // Oscillator pins
    input wire logic [1:0] remap_active, // Remap on
    input wire logic [1:0] remap_out, // Remap data
    input wire logic [1:0] remap_is_spi1, // Serial one
    input wire logic [1:0] remap_is_spi2, // Serial two
    input wire logic [1:0] par_own, // Parallel owns
    input wire logic [1:0] par_out, // Parallel data
    input wire logic [1:0] par_oe, // Parallel enable
    input wire papc_pkg::papc_pad_type pad, // Pad drive
    input wire logic parallel_port_ttl_select, // TTL select
    input wire logic calendar_pin_out, // Calendar data
    input wire logic calendar_pin_oe // Calendar enable
);
    import papc_pkg::*;
    logic [ADDR_W-1:0] rd_addr_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address of the read under way
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            rd_addr_reg <= s_axi_araddr;
        end
    end
    a_cal_gate: assert property (
        !calendar_pin_oe |-> !calendar_pin_out)
        else $error("calendar data high while disabled");
    a_pin4_idle: assert property (
        pad.oe[4] == 1'b0)
        else $error("missing pin four driven");
    a_osc_float: assert property (
        osc_pins_taken |=> pad.oe[7:6] == 2'b00)
        else $error("oscillator pins driven");
    a_par_owns: assert property (
        par_own[0] |=> pad.oe[0] == $past(par_oe[0]) && (!pad.oe[0] || pad.out[0] == $past(par_out[0])))
        else $error("parallel port lost pin zero");
    a_remap_drive: assert property (
        remap_active[0] && !par_own[0] && !remap_is_spi1[0] && !remap_is_spi2[0]
        |=> !pad.oe[0] || pad.out[0] == $past(remap_out[0]))
        else $error("remapped output not on pin zero");
    a_ttl_buffer: assert property (
        par_own[0] && parallel_port_ttl_select ##1 parallel_port_ttl_select |-> !pad.schmitt[0])
        else $error("parallel pin not on ttl buffer");
    a_odc3_zeros: assert property (
        s_axi_rvalid && rd_addr_reg == `PAPC_OFF_OPEN_DRAIN_THREE
        |-> s_axi_rdata[6:2] == 5'h00 && s_axi_rdata[31:8] == 24'h000000)
        else $error("unused open-drain bits read high");
    a_rd_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule : papc_top_asserts
`default_nettype wire

// ===== verif/papc_top_tb.sv
// Self-checking bench for the port A pad block
`timescale 1ns/10ps
`default_nettype none
`include "papc_params.svh"
module papc_top_tb;
    import papc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, remap_active, remap_out, remap_is_spi1, remap_is_spi2;
    logic [1:0] par_own, par_out, par_oe, par_in;
    logic [7:0] pad_in, world, analog_in_enable;
    logic osc_pins_taken, parallel_port_ttl_select, pulse_delay_input, bandgap_out;
    logic cal_alarm_pulse, cal_seconds_clock, intrc_clk, sec_osc_clk, ext_timer_clk;
    logic calendar_pin_out, calendar_pin_oe;
    papc_pad_type pad;
    int num_errors, n_tests;
    papc_top #(.ADDR_W(12)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad,
        .osc_pins_taken, .remap_active, .remap_out, .remap_is_spi1, .remap_is_spi2, .par_own,
        .par_out, .par_oe, .par_in, .parallel_port_ttl_select, .pulse_delay_input, .bandgap_out,
        .analog_in_enable, .cal_alarm_pulse, .cal_seconds_clock, .intrc_clk, .sec_osc_clk,
        .ext_timer_clk, .calendar_pin_out, .calendar_pin_oe
    );
    papc_pin_model pins (.pad, .world, .pad_in);
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `PAPC_RESP_OKAY);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = `PAPC_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task settle;
        repeat (8) @(negedge aclk);
    endtask : settle
    task t_reset;
        rd(`PAPC_OFF_DIRECTION, 32'h000000EF);
        rd(`PAPC_OFF_ANALOG, 32'h00000000);
        rd(`PAPC_OFF_PINS, 32'h000000C0);
        rd(`PAPC_OFF_OPEN_DRAIN_THREE, 32'h00000000);
        rd(`PAPC_OFF_PAD_CONFIG_ONE, 32'h00000000);
        settle;
        chk("analog", 32'h0000002F, {24'h0, analog_in_enable});
        chk("oe", 32'h00000000, {24'h0, pad.oe});
    endtask : t_reset
    task t_masks;
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'hFF);
        rd(`PAPC_OFF_OPEN_DRAIN_THREE, 32'h00000083);
        wr(`PAPC_OFF_PAD_CONFIG_ONE, 8'hFF);
        rd(`PAPC_OFF_PAD_CONFIG_ONE, 32'h00000007);
        settle;
        chk("ttl", 32'h1, {31'h0, parallel_port_ttl_select});
        wr(12'hF20, 8'h55, `PAPC_RESP_SLVERR);
        rd(12'hF20, 32'h00000000, `PAPC_RESP_SLVERR);
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'h00);
        wr(`PAPC_OFF_PAD_CONFIG_ONE, 8'h00);
        settle;
        chk("ttl", 32'h0, {31'h0, parallel_port_ttl_select});
    endtask : t_masks
    task t_port;
        wr(`PAPC_OFF_ANALOG, 8'h1F);
        wr(`PAPC_OFF_LATCH, 8'hA5);
        wr(`PAPC_OFF_DIRECTION, 8'h00);
        settle;
        chk("oe", 32'h000000EF, {24'h0, pad.oe});
        chk("out", 32'h000000A5, {24'h0, pad.out & pad.oe});
        rd(`PAPC_OFF_PINS, 32'h000000A5);
        wr(`PAPC_OFF_PINS, 8'h3C);
        rd(`PAPC_OFF_LATCH, 32'h0000002C);
        @(posedge aclk);
        osc_pins_taken <= 1'b1;
        settle;
        rd(`PAPC_OFF_PINS, 32'h0000002C);
        @(posedge aclk);
        osc_pins_taken <= 1'b0;
        world <= 8'h5A;
        wr(`PAPC_OFF_DIRECTION, 8'hFF);
        settle;
        chk("oe", 32'h00000000, {24'h0, pad.oe});
        rd(`PAPC_OFF_PINS, 32'h0000004A);
        rd(`PAPC_OFF_LATCH, 32'h0000002C);
        wr(`PAPC_OFF_ANALOG, 8'h00);
        settle;
        rd(`PAPC_OFF_PINS, 32'h00000040);
        wr(`PAPC_OFF_DIRECTION, 8'h00);
        settle;
        chk("out", 32'h0000002C, {24'h0, pad.out & pad.oe});
        wr(`PAPC_OFF_DIRECTION, 8'hFF);
        wr(`PAPC_OFF_ANALOG, 8'h1F);
    endtask : t_port
    task t_pulse;
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'h80);
        wr(`PAPC_OFF_MISC, 8'h08);
        settle;
        chk("pulse", 32'h1, {31'h0, pulse_delay_input});
        chk("bandgap", 32'h1, {31'h0, bandgap_out});
        chk("par_in", 32'h2, {30'h0, par_in});
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'h00);
        wr(`PAPC_OFF_MISC, 8'h00);
        settle;
        chk("pulse", 32'h0, {31'h0, pulse_delay_input});
        chk("bandgap", 32'h0, {31'h0, bandgap_out});
    endtask : t_pulse
    task cal(input logic [7:0] cfg, input logic [7:0] misc, input logic [1:0] e);
        wr(`PAPC_OFF_PAD_CONFIG_ONE, cfg);
        wr(`PAPC_OFF_MISC, misc);
        settle;
        chk("calendar", {30'h0, e}, {30'h0, calendar_pin_oe, calendar_pin_out});
    endtask : cal
    task t_calendar;
        cal(8'h00, 8'h01, 2'b11);
        cal(8'h02, 8'h01, 2'b10);
        cal(8'h04, 8'h01, 2'b11);
        cal(8'h04, 8'h03, 2'b11);
        cal(8'h04, 8'h07, 2'b10);
        cal(8'h06, 8'h01, 2'b10);
        cal(8'h00, 8'h00, 2'b00);
    endtask : t_calendar
    task t_remap;
        wr(`PAPC_OFF_PAD_CONFIG_ONE, 8'h01);
        wr(`PAPC_OFF_DIRECTION, 8'h00);
        @(posedge aclk);
        remap_active <= 2'b11;
        remap_is_spi1 <= 2'b01;
        remap_is_spi2 <= 2'b10;
        remap_out <= 2'b01;
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'h03);
        settle;
        chk("remap oe", 32'h2, {30'h0, pad.oe[1:0]});
        chk("remap out", 32'h0, {30'h0, pad.out[1:0] & pad.oe[1:0]});
        wr(`PAPC_OFF_OPEN_DRAIN_THREE, 8'h00);
        @(posedge aclk);
        remap_is_spi1 <= 2'b00;
        remap_is_spi2 <= 2'b00;
        settle;
        chk("remap oe", 32'h3, {30'h0, pad.oe[1:0]});
        chk("remap out", 32'h1, {30'h0, pad.out[1:0]});
        @(posedge aclk);
        par_own <= 2'b01;
        par_oe <= 2'b01;
        settle;
        chk("par out", 32'h0, {31'h0, pad.out[0]});
        chk("schmitt", 32'h0, {30'h0, pad.schmitt[1:0]});
    endtask : t_remap
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        num_errors = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {remap_active, remap_out, remap_is_spi1, remap_is_spi2, par_own, par_out, par_oe} = '0;
        {osc_pins_taken, cal_seconds_clock, sec_osc_clk} = '0;
        {cal_alarm_pulse, intrc_clk, ext_timer_clk} = 3'b111;
        world = 8'hFF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_masks();
        t_port();
        t_pulse();
        t_calendar();
        t_remap();
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
endmodule : papc_top_tb
bind papc_top papc_top_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .osc_pins_taken, .remap_active, .remap_out, .remap_is_spi1, .remap_is_spi2,
    .par_own, .par_out, .par_oe, .pad, .parallel_port_ttl_select, .calendar_pin_out,
    .calendar_pin_oe
);
`default_nettype wire
